// [design/sscr_map.vh]
// register offsets, fields, reset values and timing for the spi setup group
`ifndef SSCR_MAP_VH
`define SSCR_MAP_VH
`define SSCR_ADDR_W            15
`define SSCR_OFS_SETUP         15'h0000
`define SSCR_OFS_POWER         15'h0002
`define SSCR_OFS_CATEGORY      15'h0003
`define SSCR_OFS_PARTNUM_LO    15'h0004
`define SSCR_OFS_PARTNUM_HI    15'h0005
`define SSCR_OFS_REVISION      15'h0006
`define SSCR_OFS_MAKER_LO      15'h000C
`define SSCR_OFS_MAKER_HI      15'h000D
`define SSCR_OFS_USER_PORT     15'h0010
`define SSCR_BIT_SOFT_RESET    7
`define SSCR_BIT_DIRECTION     5
`define SSCR_BIT_FOUR_WIRE     4
`define SSCR_BIT_ADDR_FREEZE   0
`define SSCR_RST_SETUP         8'h30
`define SSCR_RST_POWER         8'h00
`define SSCR_RST_USER_PORT     8'h00
`define SSCR_RESET_TIME_NS     750
`define SSCR_CLK_PERIOD_NS     4
`define SSCR_RESET_CYCLES      (`SSCR_RESET_TIME_NS / `SSCR_CLK_PERIOD_NS)
`endif

// [design/sscr_shifter.v]
// spi frame shifter: command, address and streamed data bytes
`timescale 1ns/1ps
`include "sscr_map.vh"
module sscr_shifter (
	clk,
	rstn,
	spi_cs_n,
	spi_sdi,
	rd_data,
	step_dir_up,
	addr_freeze,
	bus_hold,
	acc_addr,
	wr_en,
	wr_data,
	rd_sample,
	sdo_bit
);
	input  wire        clk;
	input  wire        rstn;
	input  wire        spi_cs_n;
	input  wire        spi_sdi;
	input  wire [7:0]  rd_data;
	input  wire        step_dir_up;
	input  wire        addr_freeze;
	input  wire        bus_hold;
	output wire [14:0] acc_addr;
	output reg         wr_en;
	output wire [7:0]  wr_data;
	output reg         rd_sample;
	output wire        sdo_bit;

	reg  [4:0]  cnt_r;
	reg         hdr_done_r;
	reg         rd_r;
	reg  [14:0] addr_r;
	reg  [7:0]  sh_r;
	reg  [7:0]  out_r;
	reg  [14:0] wr_addr_r;

	// write strobe trails the byte by one clk, so it must use the
	// address and byte latched before the streaming step
	assign acc_addr = wr_en ? wr_addr_r : addr_r;
	assign wr_data  = sh_r;
	assign sdo_bit  = out_r[7];

	// ****************************************
	// one spi bit per clk while the frame is open and bus_hold is low
	// ****************************************
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r      <= 5'd0;
			hdr_done_r <= 1'b0;
			rd_r       <= 1'b0;
			addr_r     <= 15'h0000;
			sh_r       <= 8'h00;
			out_r      <= 8'h00;
			wr_addr_r  <= 15'h0000;
			wr_en      <= 1'b0;
			rd_sample  <= 1'b0;
		end else begin
			wr_en     <= 1'b0;
			rd_sample <= 1'b0;
			if (spi_cs_n || bus_hold) begin
				cnt_r      <= 5'd0;
				hdr_done_r <= 1'b0;
			end else if (!hdr_done_r) begin
				sh_r  <= {sh_r[6:0], spi_sdi};
				cnt_r <= cnt_r + 5'd1;
				if (cnt_r == 5'd0)
					rd_r <= spi_sdi;
				else
					addr_r <= {addr_r[13:0], spi_sdi};
				if (cnt_r == 5'd15) begin
					hdr_done_r <= 1'b1;
					cnt_r      <= 5'd0;
					rd_sample  <= 1'b1;
				end
			end else begin
				sh_r  <= {sh_r[6:0], spi_sdi};
				out_r <= {out_r[6:0], 1'b0};
				cnt_r <= cnt_r + 5'd1;
				if (cnt_r == 5'd0 && rd_r)
					out_r <= rd_data;
				if (cnt_r == 5'd7) begin
					cnt_r     <= 5'd0;
					wr_addr_r <= addr_r;
					wr_en     <= ~rd_r;
				end
				// advance once the byte is finished
				if (cnt_r == 5'd7 && !addr_freeze) begin
					if (step_dir_up)
						addr_r <= addr_r + 15'd1;
					else
						addr_r <= addr_r - 15'd1;
				end
				if (cnt_r == 5'd7 && rd_r)
					rd_sample <= 1'b1;
			end
		end
	end
endmodule

// [design/sscr_regs.v]
// spi standard setup register group of the converter
`timescale 1ns/1ps
`include "sscr_map.vh"
module sscr_regs #(
	parameter [3:0]  CATEGORY_CODE = 4'h5,     // arbitrary value
	parameter [15:0] PART_NUMBER   = 16'h1234, // arbitrary value
	parameter [7:0]  REVISION      = 8'h07,    // arbitrary value
	parameter [15:0] MAKER_CODE    = 16'h0ABC  // arbitrary value
) (
	clk,
	rstn,
	spi_cs_n,
	spi_sdi,
	spi_sdo,
	device_reset,
	power_down,
	reset_busy
);
	input  wire clk;
	input  wire rstn;
	input  wire spi_cs_n;
	input  wire spi_sdi;
	output reg  spi_sdo;
	output reg  device_reset;
	output reg  power_down;
	output reg  reset_busy;

	// rounds down: 187 clk of 4 ns stay inside the 750 ns budget
	localparam [31:0] RST_CNT_W = `SSCR_RESET_CYCLES;
	localparam [7:0]  RST_CNT   = RST_CNT_W[7:0];
	localparam [7:0]  RST_SETUP = `SSCR_RST_SETUP;
	localparam [7:0]  RST_POWER = `SSCR_RST_POWER;

	reg        soft_rst_r;
	reg        dir_up_r;
	reg  [1:0] pwr_mode_r;
	reg  [7:0] user_port_r;
	reg  [7:0] rst_cnt_r;
	reg  [7:0] rd_data;
	wire [14:0] acc_addr;
	wire        wr_en;
	wire [7:0]  wr_data;
	wire        sdo_bit;

	// ****************************************
	// frame shifter, held idle while resetting
	// ****************************************
	sscr_shifter u_shift (
		.clk         (clk),
		.rstn        (rstn),
		.spi_cs_n    (spi_cs_n),
		.spi_sdi     (spi_sdi),
		.rd_data     (rd_data),
		.step_dir_up (dir_up_r),
		.addr_freeze (user_port_r[`SSCR_BIT_ADDR_FREEZE]),
		.bus_hold    (soft_rst_r),
		.acc_addr    (acc_addr),
		.wr_en       (wr_en),
		.wr_data     (wr_data),
		.rd_sample   (),
		.sdo_bit     (sdo_bit)
	);

	// ****************************************
	// read decode
	// ****************************************
	always @* begin
		case (acc_addr)
		`SSCR_OFS_SETUP:
			rd_data = {soft_rst_r, 1'b0, dir_up_r, 1'b1, 4'h0};
		`SSCR_OFS_POWER:
			rd_data = {6'b00_0000, pwr_mode_r};
		`SSCR_OFS_CATEGORY:
			rd_data = {4'h0, CATEGORY_CODE};
		`SSCR_OFS_PARTNUM_LO:
			rd_data = PART_NUMBER[7:0];
		`SSCR_OFS_PARTNUM_HI:
			rd_data = PART_NUMBER[15:8];
		`SSCR_OFS_REVISION:
			rd_data = REVISION;
		`SSCR_OFS_MAKER_LO:
			rd_data = MAKER_CODE[7:0];
		`SSCR_OFS_MAKER_HI:
			rd_data = MAKER_CODE[15:8];
		`SSCR_OFS_USER_PORT:
			rd_data = user_port_r;
		default:
			rd_data = 8'h00;
		endcase
	end

	// ****************************************
	// writable state and soft reset sequencing
	// ****************************************
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			soft_rst_r   <= 1'b0;
			dir_up_r     <= RST_SETUP[`SSCR_BIT_DIRECTION];
			pwr_mode_r   <= RST_POWER[1:0];
			user_port_r  <= `SSCR_RST_USER_PORT;
			rst_cnt_r    <= 8'h00;
			spi_sdo      <= 1'b0;
			device_reset <= 1'b0;
			power_down   <= 1'b0;
			reset_busy   <= 1'b0;
		end else begin
			spi_sdo      <= sdo_bit;
			device_reset <= soft_rst_r;
			reset_busy   <= soft_rst_r;
			// only the top mode bit matters: 2 and 3 are off
			power_down   <= pwr_mode_r[1];
			if (soft_rst_r) begin
				// everything back to reset values, then self-clear
				dir_up_r    <= RST_SETUP[`SSCR_BIT_DIRECTION];
				pwr_mode_r  <= RST_POWER[1:0];
				user_port_r <= `SSCR_RST_USER_PORT;
				rst_cnt_r   <= rst_cnt_r + 8'd1;
				if (rst_cnt_r == RST_CNT - 8'd1)
					soft_rst_r <= 1'b0;
			end else if (wr_en) begin
				rst_cnt_r <= 8'h00;
				case (acc_addr)
				`SSCR_OFS_SETUP: begin
					dir_up_r   <= wr_data[`SSCR_BIT_DIRECTION];
					soft_rst_r <= wr_data[`SSCR_BIT_SOFT_RESET];
				end
				`SSCR_OFS_POWER:
					pwr_mode_r <= wr_data[1:0];
				`SSCR_OFS_USER_PORT:
					user_port_r <= wr_data;
				default: ;
				endcase
			end
		end
	end
endmodule

// [sim/sscr_regs_sva.sv]
// port assertions for the spi setup group
`timescale 1ns/1ps
module sscr_regs_sva (
	input wire clk,
	input wire rstn,
	input wire spi_cs_n,
	input wire spi_sdi,
	input wire spi_sdo,
	input wire device_reset,
	input wire power_down,
	input wire reset_busy
);
	reg [8:0] cnt_r;
	always @(posedge clk or negedge rstn)
		if (!rstn)
			cnt_r <= 9'h000;
		else
			cnt_r <= device_reset ? cnt_r + 9'h001 : 9'h000;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_busy_mirror: assert property (reset_busy == device_reset)
		else $error("busy differs from reset");
	a_reset_span: assert property ($fell(device_reset) |->
		cnt_r inside {[186:188]}) else $error("soft reset length");
	a_reset_once: assert property ($fell(device_reset) |=>
		!device_reset[*4]) else $error("reset bit not cleared");
	a_reset_cause: assert property ($rose(device_reset) |->
		!$past(spi_cs_n, 2) || !$past(spi_cs_n, 3))
		else $error("reset without frame");
	a_pd_cleared: assert property ($rose(device_reset) |->
		##[0:2] !power_down) else $error("power mode kept");
	a_pd_held: assert property (device_reset && $past(device_reset, 2)
		|-> $stable(power_down)) else $error("frame taken in reset");
	a_pd_cause: assert property ($changed(power_down) && !device_reset
		|-> !$past(spi_cs_n, 2) || !$past(spi_cs_n, 3)
		|| !$past(spi_cs_n, 4)) else $error("power changed idle");
	a_sdo_framed: assert property ($rose(spi_sdo) |->
		!$past(spi_cs_n) || !$past(spi_cs_n, 2)) else $error("sdo idle");
	c_reset: cover property ($rose(device_reset));
	c_pd: cover property ($rose(power_down));
	c_sdo: cover property ($rose(spi_sdo));
endmodule
bind sscr_regs sscr_regs_sva chk (.clk(clk), .rstn(rstn),
	.spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
	.device_reset(device_reset), .power_down(power_down),
	.reset_busy(reset_busy));

// [sim/sscr_host_model.sv]
// spi host model for the setup group
`timescale 1ns/1ps
`include "sscr_map.vh"
module sscr_host_model (
	input  wire clk,
	output reg  cs_n,
	output reg  sdi,
	input  wire sdo
);
	reg [7:0] rx [0:3];
	integer   i;
	initial begin
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	task shift(input [15:0] w, input integer n);
		for (i = n - 1; i >= 0; i = i - 1) begin
			@(negedge clk);
			cs_n = 1'b0;
			sdi = w[i];
		end
	endtask
	task done;
		@(negedge clk);
		cs_n = 1'b1;
		// released line shows inverse, never a stale bit
		sdi = ~sdi;
	endtask
	task write(input [14:0] a, input [7:0] d);
		shift({1'b0, a}, 16);
		shift({8'h00, d}, 8);
		done;
	endtask
	task read(input [14:0] a, input integer n);
		shift({1'b1, a}, 16);
		repeat (2) @(negedge clk);
		for (i = 0; i < n * 8; i = i + 1) begin
			@(negedge clk);
			rx[i / 8][7 - i % 8] = sdo;
		end
		done;
	endtask
	task pause;
		repeat (`SSCR_RESET_CYCLES + 2) @(negedge clk);
	endtask
endmodule

// [sim/test_sscr_regs.sv]
// self-checking bench for the spi setup group
`timescale 1ns/1ps
module test_sscr_regs;
	reg     clk = 0;
	reg     rstn = 0;
	wire    cs_n, sdi, sdo, drst, pd, busy;
	integer errors = 0;
	integer total_checks = 0;
	integer v;
	always #2 clk = ~clk;
	// arbitrary identity values
	sscr_regs #(.CATEGORY_CODE(4'h9), .PART_NUMBER(16'h2B6E),
		.REVISION(8'h3C), .MAKER_CODE(16'h5D17)) dut (.clk(clk),
		.rstn(rstn), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo),
		.device_reset(drst), .power_down(pd), .reset_busy(busy));
	sscr_host_model host (.clk(clk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	task chk(input [15:0] s, input [15:0] e);
		total_checks = total_checks + 1;
		if (s !== e) begin
			errors = errors + 1;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task rd(input [14:0] a, input [7:0] e);
		host.read(a, 1);
		chk(host.rx[0], e);
	endtask
	task t_ids;
		rd(15'h0000, 8'h30);
		rd(15'h0002, 8'h00);
		rd(15'h0003, 8'h09);
		rd(15'h0006, 8'h3C);
		rd(15'h0001, 8'h00);
		host.read(15'h0004, 2);
		chk({host.rx[1], host.rx[0]}, 16'h2B6E);
		$display("ids done");
	endtask
	task t_descend;
		host.write(15'h0000, 8'h4F);
		rd(15'h0000, 8'h10);
		host.read(15'h000D, 2);
		chk({host.rx[0], host.rx[1]}, 16'h5D17);
		host.write(15'h0000, 8'h30);
		$display("descend done");
	endtask
	task t_power;
		for (v = 0; v < 4; v = v + 1) begin
			host.write(15'h0002, 8'hFC | v);
			rd(15'h0002, v);
			chk(pd, v / 2);
		end
		// power-down kept brief
		host.write(15'h0002, 8'h00);
		$display("power done");
	endtask
	task t_freeze;
		host.write(15'h0010, 8'h01);
		host.read(15'h0006, 3);
		chk(host.rx[2], 8'h3C);
		host.write(15'h0010, 8'h00);
		$display("freeze done");
	endtask
	task t_soft;
		host.write(15'h0002, 8'h03);
		host.write(15'h0000, 8'hB0);
		repeat (2) @(negedge clk);
		chk(drst, 1);
		chk(busy, 1);
		host.pause;
		chk(drst, 0);
		chk(busy, 0);
		rd(15'h0000, 8'h30);
		chk(pd, 0);
		$display("soft reset done");
	endtask
	initial begin
		#40000;
		errors = errors + 1;
		conclude;
	end
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1;
		t_ids;
		t_descend;
		t_power;
		t_freeze;
		t_soft;
		conclude;
	end
endmodule
